// [logic/sfc_pkg.sv]
/*
  Constants, field positions and helper functions of the serial flash
  configuration registers.
  Assumes: included before every other file of the block.
*/
`default_nettype none
package sfc_pkg;

  // ------------------------------------------------------------
  // register layout
  // ------------------------------------------------------------
  localparam logic [15:0] NV_DEFAULT    = 16'hFFFF;
  localparam logic [7:0]  VC_DEFAULT    = 8'hFB;
  localparam int          NV_DUMMY_LSB  = 12;
  localparam int          NV_XIP_LSB    = 9;
  localparam int          NV_DRV_LSB    = 6;
  localparam int          NV_HOLD_BIT   = 4;
  localparam int          NV_QUAD_BIT   = 3;
  localparam int          NV_DUAL_BIT   = 2;
  localparam int          VC_DUMMY_LSB  = 4;
  localparam int          VC_XIP_BIT    = 3;
  localparam int          VC_WRAP_LSB   = 0;
  localparam logic        VC_RSVD_VAL   = 1'h0;

  // ------------------------------------------------------------
  // field codes
  // ------------------------------------------------------------
  localparam logic [2:0]  XIP_SIO       = 3'h0;
  localparam logic [2:0]  XIP_DUAL_OUTPUT_FAST_READ      = 3'h1;
  localparam logic [2:0]  XIP_DUAL_IO_FAST_READ     = 3'h2;
  localparam logic [2:0]  XIP_QUAD_OUTPUT_FAST_READ      = 3'h3;
  localparam logic [2:0]  XIP_QUAD_IO_FAST_READ     = 3'h4;
  localparam logic [2:0]  XIP_OFF       = 3'h7;
  localparam logic [2:0]  DRV_DEFAULT   = 3'h7;
  localparam logic [3:0]  DUMMY_DEFAULT = 4'hF;
  localparam logic [1:0]  WRAP_16       = 2'h0;
  localparam logic [1:0]  WRAP_32       = 2'h1;
  localparam logic [1:0]  WRAP_64       = 2'h2;
  localparam logic [1:0]  WRAP_CONT     = 2'h3;
  localparam logic [1:0]  PROTO_EXT     = 2'h0;
  localparam logic [1:0]  PROTO_DUAL    = 2'h1;
  localparam logic [1:0]  PROTO_QUAD    = 2'h2;

  // ------------------------------------------------------------
  // instructions and frame lengths
  // ------------------------------------------------------------
  localparam logic [7:0]  OP_WR_VOL     = 8'h81;
  localparam logic [7:0]  OP_WR_NV      = 8'hB1;
  localparam logic [7:0]  OP_FAST_READ  = 8'h0B;
  localparam logic [4:0]  ADDR_BITS     = 5'h18;
  localparam logic [4:0]  BYTE_BITS     = 5'h08;
  localparam logic [4:0]  WORD_BITS     = 5'h10;
  localparam logic [11:0] CFG_DEFAULT   =
    {PROTO_EXT, XIP_OFF, DUMMY_DEFAULT, 1'h0, WRAP_CONT};

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic xip_on(input logic [2:0] m);
    return m <= XIP_QUAD_IO_FAST_READ;
  endfunction

  function automatic logic [3:0] dummy_count(input logic [3:0] c);
    return (c == 4'h0) ? DUMMY_DEFAULT : c;
  endfunction

  function automatic logic [2:0] lane_count(input logic [1:0] p);
    return (p == PROTO_QUAD) ? 3'h4 : (p == PROTO_DUAL) ? 3'h2 : 3'h1;
  endfunction

  function automatic logic [2:0] xip_lanes(input logic [2:0] m);
    return (m == XIP_QUAD_IO_FAST_READ) ? 3'h4 : (m == XIP_DUAL_IO_FAST_READ) ? 3'h2 : 3'h1;
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] s,
                                           input logic [3:0]  d,
                                           input logic [2:0]  n);
    if (n == 3'h4) begin
      return {s[19:0], d};
    end
    if (n == 3'h2) begin
      return {s[21:0], d[1:0]};
    end
    return {s[22:0], d[0]};
  endfunction

  function automatic logic [23:0] wrap_next(input logic [23:0] a,
                                            input logic [1:0]  w);
    logic [23:0] m;
    logic [23:0] n;
    m = (w == WRAP_16) ? 24'h00000F :
        (w == WRAP_32) ? 24'h00001F : 24'h00003F;
    n = 24'(a + 24'h000001);
    return (w == WRAP_CONT) ? n : ((a & ~m) | (n & m));
  endfunction

endpackage
`default_nettype wire

// [logic/sfc_sync.sv]
/*
  Two flip-flop level synchroniser with a chosen reset value.
  Assumes: inputs change slowly against the destination clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // destination clock
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [logic/sfc_link.sv]
/*
  Serial link side: instruction, address, dummy and read phases on the
  serial clock; captures configuration writes for the core.
  Assumes: settings arrive already synchronised to sclk; chip select
  high ends every frame.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_link (
  // link clock and frame
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        rst_n,
  input  wire logic [3:0]  dq_in,
  // settings in this domain
  input  wire logic [1:0]  proto,
  input  wire logic [2:0]  xip_mode,
  input  wire logic [3:0]  dummy,
  input  wire logic        xip_en,
  input  wire logic [1:0]  wrap,
  // write event toward the core
  output logic             wr_tog,
  output logic             wr_nv,
  output logic      [15:0] wr_data,
  // read side
  output logic             xip_keep,
  output logic      [23:0] read_addr
);
  typedef enum logic [2:0] {
    ST_OP, ST_ADDR, ST_DATA, ST_DUMMY, ST_READ, ST_IGNORE
  } sfc_link_st_type;

  sfc_link_st_type st_r;
  sfc_link_st_type st_nxt;
  sfc_link_st_type op_st_w;
  logic [4:0]      cnt_r;
  logic [4:0]      cnt_nxt;
  logic [23:0]     sh_r;
  logic            nv_cmd_r;
  wire  logic      skip_op_w = sfc_pkg::xip_on(xip_mode);
  wire  logic      in_addr_w = (st_r == ST_ADDR) ||
                               (st_r == ST_OP && skip_op_w);
  wire  logic [2:0] lanes_w  = skip_op_w ? sfc_pkg::xip_lanes(xip_mode)
                                         : sfc_pkg::lane_count(proto);
  wire  logic [23:0] sh_nxt  = sfc_pkg::shift_in(sh_r, dq_in, lanes_w);
  wire  logic [4:0] got_w    = 5'(cnt_r + {2'h0, lanes_w});
  wire  logic [4:0] need_w   = in_addr_w ? sfc_pkg::ADDR_BITS :
                               (st_r == ST_DATA && nv_cmd_r) ?
                               sfc_pkg::WORD_BITS : sfc_pkg::BYTE_BITS;
  wire  logic       done_w   = (got_w == need_w);
  wire  logic       dum_end_w = (5'(cnt_r + 5'h01) == {1'h0, dummy});
  wire  logic       first_dum_w = (st_r == ST_DUMMY) && (cnt_r == 5'h00);

  // ------------------------------------------------------------
  // instruction decode and phase sequencing
  // ------------------------------------------------------------
  assign op_st_w = (sh_nxt[7:0] == sfc_pkg::OP_FAST_READ) ? ST_ADDR :
                   (sh_nxt[7:0] == sfc_pkg::OP_WR_VOL ||
                    sh_nxt[7:0] == sfc_pkg::OP_WR_NV) ? ST_DATA : ST_IGNORE;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = got_w;
    unique case (st_r)
      ST_OP: begin
        if (done_w) begin
          st_nxt  = skip_op_w ? ST_DUMMY : op_st_w;
          cnt_nxt = 5'h00;
        end
      end
      ST_ADDR: begin
        if (done_w) begin
          st_nxt  = ST_DUMMY;
          cnt_nxt = 5'h00;
        end
      end
      ST_DATA: begin
        if (done_w) begin
          st_nxt = ST_IGNORE;
        end
      end
      ST_DUMMY: begin
        cnt_nxt = 5'(cnt_r + 5'h01);
        if (dum_end_w) begin
          st_nxt  = ST_READ;
          cnt_nxt = 5'h00;
        end
      end
      ST_READ: begin
        if (done_w) begin
          cnt_nxt = 5'h00;
        end
      end
      ST_IGNORE: cnt_nxt = cnt_r;
      default: begin
        st_nxt  = ST_IGNORE;
        cnt_nxt = cnt_r;
      end
    endcase
  end

  // ------------------------------------------------------------
  // frame state, cleared while deselected
  // ------------------------------------------------------------
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st_r      <= ST_OP;
      cnt_r     <= 5'h00;
      sh_r      <= 24'h000000;
      nv_cmd_r  <= 1'h0;
      read_addr <= 24'h000000;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      if (st_r == ST_OP && done_w) begin
        nv_cmd_r <= (sh_nxt[7:0] == sfc_pkg::OP_WR_NV);
      end
      if (in_addr_w && done_w) begin
        read_addr <= sh_nxt;
      end else if (st_r == ST_READ && done_w) begin
        read_addr <= sfc_pkg::wrap_next(read_addr, wrap);
      end
    end
  end

  // ------------------------------------------------------------
  // results that outlive the frame
  // ------------------------------------------------------------
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tog   <= 1'h0;
      wr_nv    <= 1'h0;
      wr_data  <= 16'h0000;
      xip_keep <= 1'h0;
    end else begin
      if (st_r == ST_DATA && done_w) begin
        wr_tog  <= ~wr_tog;
        wr_nv   <= nv_cmd_r;
        wr_data <= nv_cmd_r ? sh_nxt[15:0] : {8'h00, sh_nxt[7:0]};
      end
      if (first_dum_w && (xip_en || skip_op_w)) begin
        xip_keep <= ~dq_in[0];
      end
    end
  end

  a_wrap_bound: assert property (
    @(posedge sclk) disable iff (cs_n)
    st_r == ST_READ && done_w && wrap != sfc_pkg::WRAP_CONT
    |=> read_addr[23:6] == $past(read_addr[23:6]))
    else $error("wrapped read left its aligned block");

  a_wrap_cont: assert property (
    @(posedge sclk) disable iff (cs_n)
    st_r == ST_READ && done_w && wrap == sfc_pkg::WRAP_CONT
    |=> read_addr == 24'($past(read_addr) + 24'h000001))
    else $error("continuous read did not step by one");

  a_first_dummy: assert property (
    @(posedge sclk) disable iff (!rst_n)
    first_dum_w && !cs_n && xip_en
    |=> xip_keep == !$past(dq_in[0]))
    else $error("first dummy data line not captured");
endmodule
`default_nettype wire

// [logic/sfc_config_regs.sv]
/*
  Configuration registers of a serial flash: the non-volatile power-on
  settings and the volatile runtime settings, written by instructions
  on the serial link, with the decoded settings they drive.
  Assumes: clk is free running; sclk may stop outside frames; the
  power_cycle pulse comes from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - non-volatile mode field picks power-on execute-in-place, address only
// - default mode field starts in extended protocol, no execute-in-place
// - non-volatile driver field sets power-on drive, default thirty ohm
// - non-volatile hold bit gates the hold function of data line 3
// - hold function enabled by delivered default
// - quad bit at zero gives quad protocol from next power-on
// - dual bit at zero gives dual protocol from next power-on
// - both zero: quad wins over dual
// - volatile write replaces dummy and execute-in-place power-on settings
// - volatile dummy codes one to fourteen give that many cycles
// - dummy code zero acts as fifteen, the reset default
// - volatile arm bit zero allows execute-in-place, default one blocks
// - when armed, data line 0 in first dummy cycle is meaningful
// - basic variant ignores the arm bit
// - wrap codes bound reads to aligned 16, 32 or 64 bytes
// - wrap code three reads sequentially without a boundary
module sfc_config_regs #(
  parameter logic BASIC_XIP = 1'h0
) (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_cycle,
  // serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  dq_in,
  // power-on settings
  output logic      [1:0]  proto_mode,
  output logic      [2:0]  xip_por_mode,
  output logic             xip_por_active,
  output logic      [2:0]  drive_strength,
  output logic             hold_enable,
  output logic             hold_active,
  // runtime settings
  output logic      [3:0]  dummy_cycles,
  output logic             xip_enabled,
  output logic      [1:0]  wrap_mode,
  output logic             xip_keep,
  // register contents
  output logic      [15:0] nv_config,
  output logic      [7:0]  vol_config,
  // link domain read address
  output logic      [23:0] read_addr
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  wire  logic rst_int_n = rst_sync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'h0;
      rst_sync_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [15:0] nv_r;
  logic [7:0]  vcr_r;
  logic [1:0]  proto_r;
  logic [2:0]  xip_por_r;
  logic [2:0]  drv_r;
  logic        hold_en_r;
  logic        por_pend_r;
  logic        wr_seen_r;

  // ------------------------------------------------------------
  // link side and crossings
  // ------------------------------------------------------------
  logic        l_wr_tog;
  logic        l_wr_nv;
  logic [15:0] l_wr_data;
  logic        l_xip_keep;
  logic [1:0]  l_proto;
  logic [2:0]  l_xmode;
  logic [3:0]  l_dummy;
  logic        l_xen;
  logic [1:0]  l_wrap;
  logic [11:0] l_cfg;
  logic        wr_tog_s;
  logic        xip_keep_s;
  logic        dq3_s;
  wire  logic [11:0] cfg_w = {proto_r, xip_por_r, dummy_cycles,
                              xip_enabled, wrap_mode};

  assign {l_proto, l_xmode, l_dummy, l_xen, l_wrap} = l_cfg;

  sfc_sync #(
    .W    (12),
    .INIT (sfc_pkg::CFG_DEFAULT)
  ) u_link_sync (
    .clk   (sclk),
    .rst_n (rst_n),
    .d     (cfg_w),
    .q     (l_cfg)
  );

  sfc_sync #(
    .W    (3),
    .INIT (3'h1)
  ) u_core_sync (
    .clk   (clk),
    .rst_n (rst_int_n),
    .d     ({l_wr_tog, l_xip_keep, dq_in[3]}),
    .q     ({wr_tog_s, xip_keep_s, dq3_s})
  );

  sfc_link u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .rst_n     (rst_n),
    .dq_in     (dq_in),
    .proto     (l_proto),
    .xip_mode  (l_xmode),
    .dummy     (l_dummy),
    .xip_en    (l_xen),
    .wrap      (l_wrap),
    .wr_tog    (l_wr_tog),
    .wr_nv     (l_wr_nv),
    .wr_data   (l_wr_data),
    .xip_keep  (l_xip_keep),
    .read_addr (read_addr)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic       wr_edge_w = wr_tog_s ^ wr_seen_r;
  wire logic       nv_wr_w   = wr_edge_w && l_wr_nv;
  wire logic       vol_wr_w  = wr_edge_w && !l_wr_nv;
  wire logic       por_w     = por_pend_r;
  wire logic [2:0] nv_xip_w  = nv_r[sfc_pkg::NV_XIP_LSB +: 3];
  wire logic       nv_quad_w = !nv_r[sfc_pkg::NV_QUAD_BIT];
  wire logic       nv_dual_w = !nv_r[sfc_pkg::NV_DUAL_BIT];
  wire logic [1:0] nv_proto_w = nv_quad_w ? sfc_pkg::PROTO_QUAD :
                                nv_dual_w ? sfc_pkg::PROTO_DUAL :
                                sfc_pkg::PROTO_EXT;
  wire logic [7:0] vcr_por_w = {nv_r[sfc_pkg::NV_DUMMY_LSB +: 4],
                                !sfc_pkg::xip_on(nv_xip_w),
                                sfc_pkg::VC_RSVD_VAL,
                                sfc_pkg::WRAP_CONT};
  wire logic [7:0] vcr_wr_w  = {l_wr_data[7:3], sfc_pkg::VC_RSVD_VAL,
                                l_wr_data[1:0]};

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      por_pend_r <= 1'h1;
      wr_seen_r  <= 1'h0;
      nv_r       <= sfc_pkg::NV_DEFAULT;
    end else begin
      por_pend_r <= power_cycle;
      wr_seen_r  <= wr_tog_s;
      if (nv_wr_w) begin
        nv_r <= l_wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      vcr_r <= sfc_pkg::VC_DEFAULT;
    end else if (por_w) begin
      vcr_r <= vcr_por_w;
    end else if (vol_wr_w) begin
      vcr_r <= vcr_wr_w;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      proto_r   <= sfc_pkg::PROTO_EXT;
      xip_por_r <= sfc_pkg::XIP_OFF;
      drv_r     <= sfc_pkg::DRV_DEFAULT;
      hold_en_r <= 1'h1;
    end else if (por_w) begin
      proto_r   <= nv_proto_w;
      xip_por_r <= nv_xip_w;
      drv_r     <= nv_r[sfc_pkg::NV_DRV_LSB +: 3];
      hold_en_r <= nv_r[sfc_pkg::NV_HOLD_BIT];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign proto_mode     = proto_r;
  assign xip_por_mode   = xip_por_r;
  // reserved or off codes leave power-on execute-in-place inactive
  assign xip_por_active = sfc_pkg::xip_on(xip_por_r);
  assign drive_strength = drv_r;
  assign hold_enable    = hold_en_r;
  // hold only when enabled, protocol not quad and line 3 low
  assign hold_active    = hold_en_r && (proto_r != sfc_pkg::PROTO_QUAD)
                          && !dq3_s;
  assign dummy_cycles   = sfc_pkg::dummy_count(
                            vcr_r[sfc_pkg::VC_DUMMY_LSB +: 4]);
  assign xip_enabled    = BASIC_XIP || !vcr_r[sfc_pkg::VC_XIP_BIT];
  assign wrap_mode      = vcr_r[sfc_pkg::VC_WRAP_LSB +: 2];
  assign xip_keep       = xip_keep_s;
  assign nv_config      = nv_r;
  assign vol_config     = vcr_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_int_n);

  sequence s_por;
    por_w;
  endsequence

  sequence s_vol_wr;
    vol_wr_w && !por_w;
  endsequence

  a_por_xip_load: assert property (
    s_por |=> xip_por_mode == $past(nv_xip_w))
    else $error("power-on mode field not loaded");

  a_por_ext_default: assert property (
    s_por ##0 (nv_xip_w == sfc_pkg::XIP_OFF) |=> !xip_por_active
    ##1 !xip_por_active)
    else $error("mode off still shows execute-in-place");

  a_por_drive: assert property (s_por |=>
    drive_strength == $past(nv_r[sfc_pkg::NV_DRV_LSB +: 3]))
    else $error("driver setting not loaded");

  a_hold_gate: assert property (!hold_enable |-> !hold_active)
    else $error("hold active while disabled");

  a_hold_default: assert property (
    s_por ##0 nv_r[sfc_pkg::NV_HOLD_BIT] |=> hold_enable)
    else $error("hold not enabled by default bit");

  a_quad_proto: assert property (s_por ##0 nv_quad_w |=>
    proto_mode == sfc_pkg::PROTO_QUAD)
    else $error("quad protocol not chosen");

  a_dual_proto: assert property (
    s_por ##0 !nv_quad_w && nv_dual_w |=> proto_mode == sfc_pkg::PROTO_DUAL)
    else $error("dual protocol not chosen");

  a_ext_proto: assert property (
    s_por ##0 !nv_quad_w && !nv_dual_w |=> proto_mode == sfc_pkg::PROTO_EXT)
    else $error("extended protocol not kept");

  a_vol_write: assert property (s_vol_wr |=>
    vol_config[7:3] == $past(l_wr_data[7:3])
    && vol_config[1:0] == $past(l_wr_data[1:0]))
    else $error("volatile write not applied");

  a_dummy_code: assert property (
    vol_config[7:4] != 4'h0 |-> dummy_cycles == vol_config[7:4])
    else $error("dummy count differs from code");

  a_dummy_zero: assert property (
    vol_config[7:4] == 4'h0 |-> dummy_cycles == 4'hF)
    else $error("dummy code zero not fifteen");

  a_xip_arm: assert property (
    !BASIC_XIP |-> xip_enabled == !vol_config[3])
    else $error("arm bit not honoured");

  a_vol_reload: assert property (s_por |=>
    vol_config[7:4] == $past(nv_r[15:12])
    && wrap_mode == sfc_pkg::WRAP_CONT)
    else $error("volatile not reloaded at power-on");
endmodule
`default_nettype wire

// [test/sfc_host.sv]
/*
  Host model of the serial link: one-lane frames, mode 0 clock.
  Assumes: the caller keeps write frames far enough apart.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
  // link pins
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] dq_in
);
  initial begin
    sclk  = 1'h0;
    cs_n  = 1'h1;
    dq_in = 4'hF;
  end
  // ------------------------------------------------------------
  // frame tasks
  // ------------------------------------------------------------
  // dq0 driven with a chosen value in every cycle
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      dq_in = {1'h1, ~dq_in[2:1], v[i]};
      #15 sclk = 1'h1;
      #15 sclk = 1'h0;
    end
  endtask
  task automatic start();
    cs_n = 1'h0;
    #15;
  endtask
  // released lines: dq3 pulled up, the rest inverted
  task automatic stop();
    #15 cs_n = 1'h1;
    dq_in = {1'h1, ~dq_in[2:0]};
  endtask
  task automatic pin3(input logic v);
    dq_in[3] = v;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
/*
  Self-checking bench of the configuration registers.
  Assumes: the host model drives the link; sclk stops between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        power_cycle = 1'h0;
  wire logic   sclk;
  wire logic   cs_n;
  wire logic [3:0] dq_in;
  logic [1:0]  proto_mode, wrap_mode;
  logic [2:0]  xip_por_mode, drive_strength;
  logic        xip_por_active, hold_enable, hold_active;
  logic        xip_enabled, xip_keep;
  logic [3:0]  dummy_cycles;
  logic [15:0] nv_config;
  logic [7:0]  vol_config;
  logic [23:0] read_addr, a, m;
  logic [15:0] nvv [6] = '{16'hFFFB, 16'hFFF3, 16'hFFF7, 16'h39EF,
                           16'h0A7F, 16'h517F};
  int          bad_count = 0;
  int          checks_done = 0;
  always #2 clk = ~clk;
  sfc_config_regs sfc_config_regs_inst (.clk(clk), .rst_n(rst_n),
    .power_cycle(power_cycle), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
    .proto_mode(proto_mode), .xip_por_mode(xip_por_mode),
    .xip_por_active(xip_por_active), .drive_strength(drive_strength),
    .hold_enable(hold_enable), .hold_active(hold_active),
    .dummy_cycles(dummy_cycles), .xip_enabled(xip_enabled),
    .wrap_mode(wrap_mode), .xip_keep(xip_keep), .nv_config(nv_config),
    .vol_config(vol_config), .read_addr(read_addr));
  sfc_host sfc_host_inst (.sclk(sclk), .cs_n(cs_n), .dq_in(dq_in));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk) rst_n = 1'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] op, input logic [15:0] d, int n);
    sfc_host_inst.start();
    sfc_host_inst.shift({24'h0, op}, 8);
    sfc_host_inst.shift({16'h0, d}, n);
    sfc_host_inst.stop();
    repeat (12) @(negedge clk);
  endtask
  task automatic pcycle();
    @(negedge clk) power_cycle = 1'h1;
    @(negedge clk) power_cycle = 1'h0;
    repeat (4) @(negedge clk);
  endtask
  task automatic chk_nv(input logic [15:0] b);
    logic on;
    on = b[11:9] <= 3'h4;
    chk(proto_mode, !b[3] ? 2 : !b[2] ? 1 : 0);
    chk(xip_por_mode, b[11:9]);
    chk(xip_por_active, on);
    chk(drive_strength, b[8:6]);
    chk(hold_enable, b[4]);
    chk(dummy_cycles, b[15:12] == 0 ? 15 : b[15:12]);
    chk(vol_config, {b[15:12], ~on, 3'h3});
    chk(xip_enabled, on);
    chk(wrap_mode, 2'h3);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    do_reset();
    chk_nv(16'hFFFF);
    chk(nv_config, 16'hFFFF);
    foreach (nvv[i]) begin
      do_reset();
      wr(8'hB1, nvv[i], 16);
      chk(nv_config, nvv[i]);
      chk(proto_mode, 2'h0);
      wr(8'h81, 16'h0000, 8);
      pcycle();
      chk_nv(nvv[i]);
      sfc_host_inst.pin3(1'h0);
      repeat (6) @(negedge clk);
      chk(hold_active, nvv[i][4] & nvv[i][3]);
      sfc_host_inst.pin3(1'h1);
    end
    do_reset();
    for (int c = 0; c < 16; c++) begin
      wr(8'h81, {8'h0, 4'(c), c[0], c[1], c[1:0]}, 8);
      chk(vol_config, {4'(c), c[0], 1'h0, c[1:0]});
      chk(dummy_cycles, c == 0 ? 15 : c);
      chk(xip_enabled, !c[0]);
      chk(wrap_mode, c[1:0]);
    end
    for (int w = 0; w < 4; w++) begin
      wr(8'h81, {8'h0, 4'h1, w[0], 1'h0, w[1:0]}, 8);
      a = 24'h00003E;
      m = w == 0 ? 24'hF : w == 1 ? 24'h1F : 24'h3F;
      sfc_host_inst.start();
      sfc_host_inst.shift({8'h0B, a}, 32);
      chk(read_addr, a);
      // dq0 moves the captured level only in armed frames
      sfc_host_inst.shift({31'h0, w[1] ^ w[0]}, 1);
      for (int k = 0; k < 3; k++) begin
        sfc_host_inst.shift(32'h0, 8);
        a = w == 3 ? a + 1 : (a & ~m) | ((a + 1) & m);
        chk(read_addr, a);
      end
      repeat (6) @(negedge clk);
      chk(xip_keep, !w[1]);
      sfc_host_inst.stop();
      repeat (12) @(negedge clk);
    end
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
